// ===== bus_master_model.sv
// Purpose: behavioural two-wire bus master facing the read path
// Assumes: 125 ns serial clock period, open-drain wire resolved by the bench
// Notes: serial clock stands high between frames; results pulse on res_o
`timescale 1ns/1ps
module bus_master_model (
  // serial pins
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i,
  // received value
  output logic res_o,
  output logic [7:0] res_data_o
);
  localparam realtime HALF = 62.5;
  // idle bus: clock high, data released
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    res_o = 1'b0;
    res_data_o = 8'h00;
  end
  // one clock pulse; data set well after the fall, sampled just before the next fall
  task automatic bit_cyc(input logic b, output logic s);
    #16 sda_low_o = !b;
    #(HALF - 16) scl_o = 1'b1;
    #(HALF - 1) s = sda_i;
    #1 scl_o = 1'b0;
  endtask : bit_cyc
  // hand a byte or an ack level to the bench
  task automatic emit(input logic [7:0] v);
    res_data_o = v;
    res_o = 1'b1;
    #1 res_o = 1'b0;
  endtask : emit
  // start or repeated start
  task automatic start();
    if (!scl_o) begin
      #16 sda_low_o = 1'b0;
      #(HALF - 16) scl_o = 1'b1;
      #(HALF);
    end
    sda_low_o = 1'b1;
    #(HALF) scl_o = 1'b0;
  endtask : start
  // stop ends a frame; the word-address write ends on a repeated start instead
  task automatic stop();
    #16 sda_low_o = 1'b1;
    #(HALF - 16) scl_o = 1'b1;
    #(HALF) sda_low_o = 1'b0;
    #(HALF);
  endtask : stop
  // send a byte, report the ninth-bit level (00 ack, 01 no ack)
  task automatic wr_byte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(d[i], s);
    bit_cyc(1'b1, s);
    emit({7'h00, s});
  endtask : wr_byte
  // receive a byte, then ack when more is wanted
  task automatic rd_byte(input logic ack);
    logic s;
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < 8; i++) begin
      bit_cyc(1'b1, s);
      d = {d[6:0], s};
    end
    bit_cyc(!ack, s);
    emit(d);
  endtask : rd_byte
endmodule : bus_master_model

// ===== rd_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, read data taken straight from the array
// Notes: width and depth are parameters
`timescale 1ns/1ps
module rd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  // write side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // read side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  // full and empty from the occupancy count
  assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rp_ff];

  // next pointers and count
  always_comb begin
    nxt_wp = push ? AW'(wp_ff + 1'b1) : wp_ff;
    nxt_rp = pop ? AW'(rp_ff + 1'b1) : rp_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_i) begin
      nxt_wp = '0;
      nxt_rp = '0;
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage array
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_ff] <= in_data_i;
    end
  end
endmodule : rd_fifo

// ===== rtc_rd_pkg.sv
// Purpose: shared constants and carriers for the serial read path
// Assumes: 125 MHz system clock, serial clock sampled as plain input
// Notes: device identifier value is arbitrary
package rtc_rd_pkg;
  // identifier compared against the top seven bits (arbitrary value)
  localparam logic [6:0] DEV_ID = 7'h2A;
  // pointer range
  localparam logic [4:0] LAST_LOC = 5'h13;
  localparam logic [4:0] PTR_RST = 5'h00;
  localparam int PTR_W = 5;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // one byte fetched from the register space with its location
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
  } rd_word_t;

  // decoded bus events from the synchronised pins
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } bus_evt_t;
endpackage : rtc_rd_pkg

// ===== rtc_serial_read_path.sv
// Purpose: two-wire slave read path with auto-incrementing pointer
// Assumes: serial pins sampled by clk_i, register contents on a fetch port
// Notes: fetched bytes pass through a fifo before the shifter
`timescale 1ns/1ps
module rtc_serial_read_path #(
  parameter int DEPTH = rtc_rd_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // register fetch port
  output logic fetch_req_o,
  output logic [4:0] fetch_addr_o,
  input wire logic fetch_ready_i,
  input wire logic [7:0] fetch_data_i,
  // status
  output logic [4:0] ptr_o,
  output logic busy_o
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR_ID, S_WORD, S_WAIT_RS, S_SEND, S_MACK, S_HOLD} st_t;
  st_t st_ff, nxt_st;
  logic [1:0] scl_sync_ff, sda_sync_ff;
  logic scl_d_ff, sda_d_ff;
  rtc_rd_pkg::bus_evt_t evt;
  logic [7:0] sh_ff, nxt_sh;
  logic [3:0] bit_ff, nxt_bit;
  logic [4:0] ptr_ff, nxt_ptr, fptr_ff, nxt_fptr;
  logic ack_ff, nxt_ack, oe_ff, nxt_oe, out_ff, nxt_out;
  logic rd_ff, nxt_rd;
  logic f_in_valid, f_in_ready, f_out_valid, f_pop, flush;
  rtc_rd_pkg::rd_word_t f_in, f_out;

  // two-stage synchronisers, then one delay for edge finding
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_i};
      sda_sync_ff <= {sda_sync_ff[0], sda_i};
      scl_d_ff <= scl_sync_ff[1];
      sda_d_ff <= sda_sync_ff[1];
    end
  end

  // bus events from synchronised levels
  always_comb begin
    evt.start = scl_sync_ff[1] && scl_d_ff && sda_d_ff && !sda_sync_ff[1];
    evt.stop = scl_sync_ff[1] && scl_d_ff && !sda_d_ff && sda_sync_ff[1];
    evt.rise = scl_sync_ff[1] && !scl_d_ff;
    evt.fall = !scl_sync_ff[1] && scl_d_ff;
  end

  // prefetch path: requests stream from fptr into the fifo
  assign fetch_req_o = rd_ff && f_in_ready;
  assign fetch_addr_o = fptr_ff;
  assign f_in_valid = fetch_req_o && fetch_ready_i;
  assign f_in.addr = fptr_ff;
  assign f_in.data = fetch_data_i;
  assign flush = evt.start || evt.stop;

  rd_fifo #(
    .WIDTH($bits(rtc_rd_pkg::rd_word_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(flush),
    .in_valid_i(f_in_valid),
    .in_ready_o(f_in_ready),
    .in_data_i(f_in),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_out)
  );

  // byte-level state machine
  always_comb begin
    nxt_st = st_ff;
    nxt_sh = sh_ff;
    nxt_bit = bit_ff;
    nxt_ptr = ptr_ff;
    nxt_fptr = fptr_ff;
    nxt_ack = ack_ff;
    nxt_oe = oe_ff;
    nxt_out = out_ff;
    nxt_rd = rd_ff;
    f_pop = 1'b0;
    if (f_in_valid) begin
      nxt_fptr = (fptr_ff == rtc_rd_pkg::LAST_LOC) ? rtc_rd_pkg::PTR_RST : 5'(fptr_ff + 1'b1);
    end
    if (evt.start) begin
      nxt_st = S_ADDR_ID;
      nxt_bit = '0;
      nxt_oe = 1'b0;
      nxt_rd = 1'b0;
      nxt_ack = 1'b0;
      nxt_fptr = ptr_ff;
    end else if (evt.stop) begin
      nxt_st = S_IDLE;
      nxt_oe = 1'b0;
      nxt_rd = 1'b0;
      nxt_ack = 1'b0;
    end else begin
      case (st_ff)
        S_IDLE, S_HOLD: begin
          nxt_oe = 1'b0;
        end
        S_ADDR_ID, S_WORD: begin
          if (evt.rise && bit_ff <= rtc_rd_pkg::BIT_LAST) begin
            nxt_sh = {sh_ff[6:0], sda_sync_ff[1]};
            nxt_bit = 4'(bit_ff + 1'b1);
          end
          if (evt.fall && bit_ff == rtc_rd_pkg::BIT_ACK && !ack_ff) begin
            if (st_ff == S_WORD) begin
              nxt_ptr = sh_ff[4:0];
              nxt_fptr = sh_ff[4:0];
              nxt_oe = 1'b1;
              nxt_out = 1'b0;
              nxt_ack = 1'b1;
            end else if (sh_ff[7:1] == rtc_rd_pkg::DEV_ID) begin
              nxt_oe = 1'b1;
              nxt_out = 1'b0;
              nxt_ack = 1'b1;
              nxt_rd = sh_ff[0];
            end else begin
              nxt_st = S_HOLD;
            end
          end else if (evt.fall && ack_ff) begin
            nxt_ack = 1'b0;
            nxt_bit = '0;
            if (st_ff == S_WORD) begin
              nxt_oe = 1'b0;
              nxt_st = S_WAIT_RS;
            end else if (rd_ff) begin
              nxt_st = S_SEND;
              nxt_oe = 1'b0;
            end else begin
              nxt_oe = 1'b0;
              nxt_st = S_WORD;
            end
          end
        end
        S_WAIT_RS: begin
          nxt_oe = 1'b0;
        end
        S_SEND: begin
          // drive next bit while scl low; load a byte at bit zero, only once scl is low
          if (bit_ff == 4'h0 && f_out_valid && !oe_ff && !scl_sync_ff[1]) begin
            nxt_sh = f_out.data;
            nxt_ptr = f_out.addr;
            f_pop = 1'b1;
            nxt_oe = 1'b1;
            nxt_out = f_out.data[7];
            nxt_bit = 4'h1;
          end else if (evt.fall && bit_ff != 4'h0) begin
            if (bit_ff == rtc_rd_pkg::BIT_ACK) begin
              nxt_oe = 1'b0;
              nxt_st = S_MACK;
              nxt_ptr = (ptr_ff == rtc_rd_pkg::LAST_LOC) ? rtc_rd_pkg::PTR_RST : 5'(ptr_ff + 1'b1);
            end else begin
              nxt_out = sh_ff[3'(4'h7 - bit_ff)];
              nxt_bit = 4'(bit_ff + 1'b1);
            end
          end
        end
        S_MACK: begin
          if (evt.rise) begin
            nxt_bit = '0;
            nxt_st = sda_sync_ff[1] ? S_HOLD : S_SEND;
          end
        end
        default: nxt_st = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= S_IDLE;
      sh_ff <= '0;
      bit_ff <= '0;
      ptr_ff <= rtc_rd_pkg::PTR_RST;
      fptr_ff <= rtc_rd_pkg::PTR_RST;
      ack_ff <= 1'b0;
      oe_ff <= 1'b0;
      out_ff <= 1'b1;
      rd_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      sh_ff <= nxt_sh;
      bit_ff <= nxt_bit;
      ptr_ff <= nxt_ptr;
      fptr_ff <= nxt_fptr;
      ack_ff <= nxt_ack;
      oe_ff <= nxt_oe;
      out_ff <= nxt_out;
      rd_ff <= nxt_rd;
    end
  end

  // outputs
  assign sda_o = out_ff;
  assign sda_oe_o = oe_ff;
  assign ptr_o = ptr_ff;
  assign busy_o = (st_ff != S_IDLE);

  // checks
  ptr_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff == S_SEND && evt.fall && bit_ff == 4'h8 && ptr_ff == 5'h13) |=> ptr_ff == 5'h00)
    else $error("pointer did not wrap");
  ptr_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff == S_SEND && evt.fall && bit_ff == 4'h8 && ptr_ff < 5'h13) |=> ptr_ff == $past(ptr_ff) + 5'h01)
    else $error("pointer did not step");
  nack_rel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff == S_HOLD) |-> !sda_oe_o)
    else $error("data driven after no-acknowledge");
  id_miss_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff == S_ADDR_ID && evt.fall && bit_ff == 4'h8 && !ack_ff && sh_ff[7:1] != rtc_rd_pkg::DEV_ID) |=> !sda_oe_o)
    else $error("acknowledged a foreign identifier");
  ack_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_ff && sda_oe_o) |-> !sda_o)
    else $error("acknowledge not low");
  stop_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    evt.stop |=> (st_ff == S_IDLE && !sda_oe_o))
    else $error("stop did not release");
  mack_go_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff == S_MACK && evt.rise && !sda_sync_ff[1] && !evt.start && !evt.stop) |=> st_ff == S_SEND)
    else $error("acknowledged byte not followed");
  msb_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff == S_SEND && f_pop) |=> sda_o == $past(f_out.data[7]))
    else $error("first bit not msb");
  rd_cov_c: cover property (@(posedge clk_i) st_ff == S_SEND && f_pop);
  wrap_cov_c: cover property (@(posedge clk_i) ptr_ff == 5'h13 ##[1:1000] ptr_ff == 5'h00);
  nack_cov_c: cover property (@(posedge clk_i) st_ff == S_MACK ##1 st_ff == S_HOLD);
endmodule : rtc_serial_read_path

// ===== tb_rtc_serial_read_path.sv
// Purpose: self-checking bench for the serial read path
// Assumes: register space modelled by a fixed byte pattern per location
// Notes: fetch port stalls at random; expected results queued by the driver
`timescale 1ns/1ps
module tb_rtc_serial_read_path;
  logic clk_i;
  logic rst_i;
  logic fetch_ready_i;
  logic [7:0] fetch_data_i;
  logic sda_o, sda_oe_o, fetch_req_o, busy_o, scl, m_low, res;
  logic [4:0] fetch_addr_o, ptr_o;
  logic [7:0] res_data;
  logic [7:0] exp_q[$];
  logic [31:0] rng = 32'h0000365E;
  int failures = 0;
  int num_checks = 0;
  // open-drain wire with pull-up
  wire sda = !(m_low | (sda_oe_o & !sda_o));

  rtc_serial_read_path dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .fetch_req_o(fetch_req_o),
    .fetch_addr_o(fetch_addr_o), .fetch_ready_i(fetch_ready_i), .fetch_data_i(fetch_data_i),
    .ptr_o(ptr_o), .busy_o(busy_o));
  bus_master_model m_u (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda), .res_o(res), .res_data_o(res_data));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // byte held at each register location
  function automatic logic [7:0] mem(input logic [4:0] a);
    return {a, a[2:0]} ^ 8'hA5;
  endfunction : mem
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // random read: preamble, n bytes, final nack, one idle byte, stop
  task automatic read_seq(input logic [6:0] id, input logic [4:0] a, input int n);
    m_u.start();
    exp_q.push_back(8'h00);
    m_u.wr_byte({id, 1'b0});
    exp_q.push_back(8'h00);
    m_u.wr_byte({3'h0, a});
    m_u.start();
    exp_q.push_back(8'h00);
    m_u.wr_byte({id, 1'b1});
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(mem(a));
      a = (a == rtc_rd_pkg::LAST_LOC) ? rtc_rd_pkg::PTR_RST : a + 5'h01;
      m_u.rd_byte(i < n - 1);
    end
    repeat (10) @(posedge clk_i);
    chk("drive after nack", 8'h00, {7'h00, sda_oe_o});
    exp_q.push_back(8'hFF);
    m_u.rd_byte(1'b0);
    m_u.stop();
    chk("pointer after read", {3'h0, a}, {3'h0, ptr_o});
    chk("busy after stop", 8'h00, {7'h00, busy_o});
    chk("fetch after stop", 8'h00, {7'h00, fetch_req_o});
  endtask : read_seq

  // clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = !clk_i;
  end
  // fetch port answers with random stalls
  always @(posedge clk_i) begin
    #1;
    rng = xs(rng);
    fetch_ready_i = rng[0] | rng[1];
    fetch_data_i = mem(fetch_addr_o);
  end
  // result monitor takes the oldest note
  always @(posedge res) begin
    if (exp_q.size() == 0) chk("unexpected result", 8'h00, res_data);
    else chk("link result", exp_q.pop_front(), res_data);
  end
  // watchdog
  initial begin
    #500us;
    failures++;
    print_verdict();
  end
  // main sequence
  initial begin
    rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    chk("pointer after reset", 8'h00, {3'h0, ptr_o});
    chk("busy after reset", 8'h00, {7'h00, busy_o});
    $display("test reset done");
    read_seq(rtc_rd_pkg::DEV_ID, 5'h12, 4);
    $display("test wrap done");
    m_u.start();
    exp_q.push_back(8'h01);
    m_u.wr_byte({rtc_rd_pkg::DEV_ID ^ 7'h01, 1'b0});
    m_u.stop();
    read_seq(rtc_rd_pkg::DEV_ID, 5'h13, 2);
    $display("test wrong id done");
    for (int k = 0; k < 3; k++) begin
      rng = xs(rng);
      read_seq(rtc_rd_pkg::DEV_ID, 5'(rng[7:0] % 20), int'(rng[10:8]) + 1);
    end
    $display("test random reads done");
    repeat (20) @(posedge clk_i);
    chk("queue left", 8'h00, 8'(exp_q.size()));
    print_verdict();
  end
endmodule : tb_rtc_serial_read_path
